// ---- rtl/prc_pkg.sv ----
// Register map, field positions and reset values of the rail control bank
package prc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] RAIL_ENABLE_CTRL_OFS = 8'h0F;
  localparam logic [7:0] SLEEP_CTRL_OFS = 8'h10;
  localparam logic [7:0] BUCK_SWITCHING_MODE_CTRL_OFS = 8'h11;
  localparam logic [7:0] OUTPUT_DISCHARGE_CTRL_OFS = 8'h12;
  localparam logic [7:0] POWER_LEVEL_CTRL_OFS = 8'h13;
  // Writable bit masks; other positions read zero
  localparam logic [7:0] RAIL_ENABLE_MASK = 8'hDE;
  localparam logic [7:0] SLEEP_MASK = 8'hBD;
  localparam logic [7:0] SWITCHING_MASK = 8'hF0;
  localparam logic [7:0] DISCHARGE_MASK = 8'hFC;
  localparam logic [7:0] POWER_LEVEL_MASK = 8'hBC;
  // Reset values
  localparam logic [7:0] RAIL_ENABLE_RST = 8'h00;
  localparam logic [7:0] SLEEP_RST = 8'h1C;
  localparam logic [7:0] SWITCHING_RST = 8'h00;
  localparam logic [7:0] DISCHARGE_RST = 8'hF8;
  localparam logic [7:0] POWER_LEVEL_RST = 8'h00;
  // Field positions
  localparam int LOAD_SWITCH_ENABLE_BIT = 7;
  localparam int BUCK1_ENABLE_BIT = 6;
  localparam int BUCK2_ENABLE_BIT = 4;
  localparam int BUCK3_ENABLE_BIT = 3;
  localparam int BUCK4_ENABLE_BIT = 2;
  localparam int LINEAR_REG_ENABLE_BIT = 1;
  localparam int SLEEP_REQ_BIT = 0;
  localparam int LINEAR_REG_DISCHARGE_BIT = 3;
  localparam int LOAD_SWITCH_DISCHARGE_BIT = 2;
  localparam int LINEAR_REG_LOW_POWER_BIT = 2;
  localparam int LINEAR_REG_KEEP_ON_BIT = 2;
  localparam int BUCK1_KEEP_ON_BIT = 7;
  localparam int BUCK2_KEEP_ON_BIT = 5;
  localparam int BUCK3_KEEP_ON_BIT = 4;
  localparam int BUCK4_KEEP_ON_BIT = 3;
  localparam int BUCK1_LOW_POWER_BIT = 7;
  localparam int BUCK2_LOW_POWER_BIT = 5;
  localparam int BUCK3_LOW_POWER_BIT = 4;
  localparam int BUCK4_LOW_POWER_BIT = 3;
  localparam int BUCK1_FORCED_SWITCHING_BIT = 7;
  localparam int BUCK2_FORCED_SWITCHING_BIT = 6;
  localparam int BUCK3_FORCED_SWITCHING_BIT = 5;
  localparam int BUCK4_FORCED_SWITCHING_BIT = 4;
  localparam int BUCK1_DISCHARGE_BIT = 7;
  localparam int BUCK2_DISCHARGE_BIT = 6;
  localparam int BUCK3_DISCHARGE_BIT = 5;
  localparam int BUCK4_DISCHARGE_BIT = 4;
endpackage : prc_pkg

// ---- rtl/prc_power_rail_control_regs.sv ----
// Rail control register bank with sleep-aware rail outputs
//
// Contract
// R01 - Enable bit 7 switches the load switch on, reset off.
// R02 - Enable bits 6,4,3,2 enable bucks 1..4, each reset to 0.
// R03 - Enable bit 1 switches the linear regulator on, reset off.
// R04 - Sleep bit 0 requests sleep at 1 and wake at 0, reset awake.
// R05 - Sleep bit 7 keeps buck 1 alive in low power during sleep, reset 0.
// R06 - Sleep bit 5 keeps buck 2 alive in low power during sleep, reset 0.
// R07 - Sleep bit 4 keeps buck 3 alive in low power during sleep, reset 1.
// R08 - Sleep bit 3 keeps buck 4 alive in low power during sleep, reset 1.
// R09 - Sleep bit 2 keeps the linear regulator alive in sleep, reset 1.
// R10 - Mode bits 7..4 force PWM on bucks 1..4 outside low power, reset 0.
// R11 - Discharge bits 7..4 discharge disabled bucks 1..4, reset 1.
// R12 - Discharge bit 3 discharges the disabled linear regulator, reset 1.
// R13 - Discharge bit 2 discharges the disabled load switch, reset 0.
// R14 - Level bits 7,5,4,3 put bucks 1..4 in low power, reset 0.
// R15 - Level bit 2 puts the linear regulator in low power, reset 0.
// R16 - Undefined bits read zero and ignore writes.
// R17 - Rails follow enable and level; sleep drops unkept bucks and linear regulator, lowers kept ones, leaves the load switch.
`timescale 1ns/1ps
`default_nettype none
module prc_power_rail_control_regs #(
  parameter int NUM_BUCKS = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Register port from the serial control interface
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  // Buck controls, index 0 is buck 1
  output logic [3:0] o_buck_on,
  output logic [3:0] o_buck_low_power,
  output logic [3:0] o_buck_forced_switching,
  output logic [3:0] o_buck_discharge,
  // Linear regulator controls
  output logic o_linear_reg_on,
  output logic o_linear_reg_low_power,
  output logic o_linear_reg_discharge,
  // Load switch controls
  output logic o_load_switch_on,
  output logic o_load_switch_discharge,
  // Sleep state
  output logic o_sleep_active
);

  if (NUM_BUCKS != 4) begin : g_chk
    $error("prc_power_rail_control_regs: four bucks only");
  end

  logic [7:0] rail_enable_ctrl_ff;
  logic [7:0] sleep_ctrl_ff;
  logic [7:0] buck_switching_mode_ctrl_ff;
  logic [7:0] output_discharge_ctrl_ff;
  logic [7:0] power_level_ctrl_ff;
  logic [7:0] nxt_rdata;
  logic nxt_hit;

  // Bit positions of per-buck fields
  localparam int EN_POS [4] = '{prc_pkg::BUCK1_ENABLE_BIT,
    prc_pkg::BUCK2_ENABLE_BIT, prc_pkg::BUCK3_ENABLE_BIT,
    prc_pkg::BUCK4_ENABLE_BIT};
  localparam int ALIVE_POS [4] = '{prc_pkg::BUCK1_KEEP_ON_BIT,
    prc_pkg::BUCK2_KEEP_ON_BIT, prc_pkg::BUCK3_KEEP_ON_BIT,
    prc_pkg::BUCK4_KEEP_ON_BIT};
  localparam int LP_POS [4] = '{prc_pkg::BUCK1_LOW_POWER_BIT,
    prc_pkg::BUCK2_LOW_POWER_BIT, prc_pkg::BUCK3_LOW_POWER_BIT,
    prc_pkg::BUCK4_LOW_POWER_BIT};
  localparam int FS_POS [4] = '{prc_pkg::BUCK1_FORCED_SWITCHING_BIT,
    prc_pkg::BUCK2_FORCED_SWITCHING_BIT, prc_pkg::BUCK3_FORCED_SWITCHING_BIT,
    prc_pkg::BUCK4_FORCED_SWITCHING_BIT};
  localparam int DIS_POS [4] = '{prc_pkg::BUCK1_DISCHARGE_BIT,
    prc_pkg::BUCK2_DISCHARGE_BIT, prc_pkg::BUCK3_DISCHARGE_BIT,
    prc_pkg::BUCK4_DISCHARGE_BIT};

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rail_enable_ctrl_ff <= prc_pkg::RAIL_ENABLE_RST; // [R01] [R02] [R03]
    end else if (i_reg_wr && i_reg_addr == prc_pkg::RAIL_ENABLE_CTRL_OFS) begin
      rail_enable_ctrl_ff <= i_reg_wdata & prc_pkg::RAIL_ENABLE_MASK; // [R16]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sleep_ctrl_ff <= prc_pkg::SLEEP_RST; // [R05] [R07] [R08] [R09]
    end else if (i_reg_wr && i_reg_addr == prc_pkg::SLEEP_CTRL_OFS) begin
      sleep_ctrl_ff <= i_reg_wdata & prc_pkg::SLEEP_MASK; // [R16]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      buck_switching_mode_ctrl_ff <= prc_pkg::SWITCHING_RST; // [R10]
    end else if (i_reg_wr &&
                 i_reg_addr == prc_pkg::BUCK_SWITCHING_MODE_CTRL_OFS) begin
      buck_switching_mode_ctrl_ff <= i_reg_wdata & prc_pkg::SWITCHING_MASK;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      output_discharge_ctrl_ff <= prc_pkg::DISCHARGE_RST; // [R11] [R12] [R13]
    end else if (i_reg_wr &&
                 i_reg_addr == prc_pkg::OUTPUT_DISCHARGE_CTRL_OFS) begin
      output_discharge_ctrl_ff <= i_reg_wdata & prc_pkg::DISCHARGE_MASK;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      power_level_ctrl_ff <= prc_pkg::POWER_LEVEL_RST; // [R14] [R15]
    end else if (i_reg_wr && i_reg_addr == prc_pkg::POWER_LEVEL_CTRL_OFS) begin
      power_level_ctrl_ff <= i_reg_wdata & prc_pkg::POWER_LEVEL_MASK;
    end
  end

  // Read decode; unmapped addresses answer zero with no hit
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_hit = 1'b1;
    if (i_reg_addr == prc_pkg::RAIL_ENABLE_CTRL_OFS) begin
      nxt_rdata = rail_enable_ctrl_ff;
    end else if (i_reg_addr == prc_pkg::SLEEP_CTRL_OFS) begin
      nxt_rdata = sleep_ctrl_ff;
    end else if (i_reg_addr == prc_pkg::BUCK_SWITCHING_MODE_CTRL_OFS) begin
      nxt_rdata = buck_switching_mode_ctrl_ff;
    end else if (i_reg_addr == prc_pkg::OUTPUT_DISCHARGE_CTRL_OFS) begin
      nxt_rdata = output_discharge_ctrl_ff;
    end else if (i_reg_addr == prc_pkg::POWER_LEVEL_CTRL_OFS) begin
      nxt_rdata = power_level_ctrl_ff;
    end else begin
      nxt_hit = 1'b0;
    end
  end

  // Read data registered so it is stable for the serial shifter
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= nxt_rdata; // [R16]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_hit <= 1'b0;
    end else if (i_reg_rd || i_reg_wr) begin
      o_reg_hit <= nxt_hit;
    end
  end

  logic sleep_req;
  assign sleep_req = sleep_ctrl_ff[prc_pkg::SLEEP_REQ_BIT];
  assign o_sleep_active = sleep_req; // [R04]

  // Rail outputs are decoded from registers only, one cycle after a write
  for (genvar b = 0; b < NUM_BUCKS; b++) begin : g_buck
    logic en;
    logic alive;
    logic lp;
    assign en = rail_enable_ctrl_ff[EN_POS[b]]; // [R02]
    assign alive = sleep_ctrl_ff[ALIVE_POS[b]];
    assign lp = power_level_ctrl_ff[LP_POS[b]]; // [R14]
    // Sleep drops rails not kept alive, kept ones go low power
    assign o_buck_on[b] = en && (!sleep_req || alive); // [R17] [R05] [R06]
    assign o_buck_low_power[b] = o_buck_on[b] && (lp || sleep_req); // [R17]
    // Forced switching only means something outside low power
    assign o_buck_forced_switching[b] = o_buck_on[b] && !o_buck_low_power[b]
      && buck_switching_mode_ctrl_ff[FS_POS[b]]; // [R10]
    assign o_buck_discharge[b] = !o_buck_on[b]
      && output_discharge_ctrl_ff[DIS_POS[b]]; // [R11]
  end

  logic lr_alive;
  assign lr_alive = sleep_ctrl_ff[prc_pkg::LINEAR_REG_KEEP_ON_BIT];
  assign o_linear_reg_on = rail_enable_ctrl_ff[prc_pkg::LINEAR_REG_ENABLE_BIT]
    && (!sleep_req || lr_alive); // [R03] [R09] [R17]
  assign o_linear_reg_low_power = o_linear_reg_on && (sleep_req ||
    power_level_ctrl_ff[prc_pkg::LINEAR_REG_LOW_POWER_BIT]); // [R15] [R17]
  assign o_linear_reg_discharge = !o_linear_reg_on &&
    output_discharge_ctrl_ff[prc_pkg::LINEAR_REG_DISCHARGE_BIT]; // [R12]
  // Load switch has no keep-alive bit, so sleep leaves it alone
  assign o_load_switch_on =
    rail_enable_ctrl_ff[prc_pkg::LOAD_SWITCH_ENABLE_BIT]; // [R01]
  assign o_load_switch_discharge = !o_load_switch_on &&
    output_discharge_ctrl_ff[prc_pkg::LOAD_SWITCH_DISCHARGE_BIT]; // [R13]

  AST_LOAD_SWITCH_WRITE: assert property (@(posedge i_clk_sys) // [R01]
    disable iff (!i_nrst)
    i_reg_wr && i_reg_addr == prc_pkg::RAIL_ENABLE_CTRL_OFS
    |=> o_load_switch_on == $past(i_reg_wdata[7]))
    else $error("load switch did not follow write");
  AST_BUCK1_ENABLE: assert property (@(posedge i_clk_sys) // [R02]
    disable iff (!i_nrst)
    !sleep_req && rail_enable_ctrl_ff[6] |-> o_buck_on[0])
    else $error("buck 1 off while enabled and awake");
  AST_LDO_OFF: assert property (@(posedge i_clk_sys) // [R03]
    disable iff (!i_nrst)
    !rail_enable_ctrl_ff[1] |-> !o_linear_reg_on)
    else $error("linear regulator on while disabled");
  AST_SLEEP_WRITE: assert property (@(posedge i_clk_sys) // [R04]
    disable iff (!i_nrst)
    i_reg_wr && i_reg_addr == prc_pkg::SLEEP_CTRL_OFS
    |=> o_sleep_active == $past(i_reg_wdata[0]))
    else $error("sleep state did not follow write");
  AST_SLEEP_DROPS_B1: assert property (@(posedge i_clk_sys) // [R05]
    disable iff (!i_nrst)
    sleep_req && !sleep_ctrl_ff[7] |-> !o_buck_on[0])
    else $error("buck 1 on in sleep without keep-alive");
  AST_SLEEP_LP: assert property (@(posedge i_clk_sys) // [R17]
    disable iff (!i_nrst)
    sleep_req && o_buck_on[3] |-> o_buck_low_power[3]
      && !o_buck_forced_switching[3])
    else $error("buck 4 not low power in sleep");
  AST_DISCHARGE_B2: assert property (@(posedge i_clk_sys) // [R11]
    disable iff (!i_nrst)
    !o_buck_on[1] && output_discharge_ctrl_ff[6] |-> o_buck_discharge[1])
    else $error("buck 2 discharge missing");
  AST_LOAD_SWITCH_DISCHARGE: assert property (@(posedge i_clk_sys) // [R13]
    disable iff (!i_nrst)
    o_load_switch_on |-> !o_load_switch_discharge)
    else $error("load switch discharged while on");
  AST_RESERVED_ZERO: assert property (@(posedge i_clk_sys) // [R16]
    disable iff (!i_nrst)
    i_reg_rd && i_reg_addr == prc_pkg::RAIL_ENABLE_CTRL_OFS
    |=> (o_reg_rdata & ~prc_pkg::RAIL_ENABLE_MASK) == 8'h00)
    else $error("reserved bits read non-zero");
  AST_LP_LEVEL: assert property (@(posedge i_clk_sys) // [R14]
    disable iff (!i_nrst)
    o_buck_on[2] && power_level_ctrl_ff[4] |-> o_buck_low_power[2])
    else $error("buck 3 not low power when selected");

  // Unkept rails must really drop, kept ones must stay up in low power
  AST_BUCK2_DROPS: assert property (@(posedge i_clk_sys) // [R06]
    disable iff (!i_nrst)
    sleep_req && !sleep_ctrl_ff[prc_pkg::BUCK2_KEEP_ON_BIT]
    |-> !o_buck_on[1])
    else $error("buck 2 on in sleep without keep-alive");
  AST_BUCK3_KEPT: assert property (@(posedge i_clk_sys) // [R07]
    disable iff (!i_nrst)
    sleep_req && sleep_ctrl_ff[prc_pkg::BUCK3_KEEP_ON_BIT]
      && rail_enable_ctrl_ff[prc_pkg::BUCK3_ENABLE_BIT]
    |-> o_buck_on[2] && o_buck_low_power[2])
    else $error("buck 3 not kept in low power during sleep");
  AST_BUCK4_KEPT: assert property (@(posedge i_clk_sys) // [R08]
    disable iff (!i_nrst)
    sleep_req && sleep_ctrl_ff[prc_pkg::BUCK4_KEEP_ON_BIT]
      && rail_enable_ctrl_ff[prc_pkg::BUCK4_ENABLE_BIT]
    |-> o_buck_on[3] && o_buck_low_power[3])
    else $error("buck 4 not kept in low power during sleep");
  AST_LINEAR_REG_DROPS: assert property (@(posedge i_clk_sys) // [R09]
    disable iff (!i_nrst)
    sleep_req && !sleep_ctrl_ff[prc_pkg::LINEAR_REG_KEEP_ON_BIT]
    |-> !o_linear_reg_on)
    else $error("linear regulator on in sleep without keep-alive");
  AST_FORCED_SWITCHING: assert property (@(posedge i_clk_sys) // [R10]
    disable iff (!i_nrst)
    !sleep_req && o_buck_on[1]
      && !power_level_ctrl_ff[prc_pkg::BUCK2_LOW_POWER_BIT]
      && buck_switching_mode_ctrl_ff[prc_pkg::BUCK2_FORCED_SWITCHING_BIT]
    |-> o_buck_forced_switching[1])
    else $error("buck 2 forced switching missing");
  AST_BUCK1_NO_DISCHARGE: assert property (@(posedge i_clk_sys) // [R11]
    disable iff (!i_nrst)
    o_buck_on[0] |-> !o_buck_discharge[0])
    else $error("buck 1 discharged while on");
  AST_LINEAR_REG_DISCHARGE: assert property (@(posedge i_clk_sys) // [R12]
    disable iff (!i_nrst)
    !o_linear_reg_on
      && output_discharge_ctrl_ff[prc_pkg::LINEAR_REG_DISCHARGE_BIT]
    |-> o_linear_reg_discharge)
    else $error("linear regulator discharge missing");
  AST_LINEAR_REG_LOW_POWER: assert property (@(posedge i_clk_sys) // [R15]
    disable iff (!i_nrst)
    o_linear_reg_on
      && power_level_ctrl_ff[prc_pkg::LINEAR_REG_LOW_POWER_BIT]
    |-> o_linear_reg_low_power)
    else $error("linear regulator not low power when selected");
  // Range test kept apart from the read decode so a decode slip shows
  AST_UNMAPPED_READ: assert property (@(posedge i_clk_sys) // [R16]
    disable iff (!i_nrst)
    i_reg_rd && (i_reg_addr < prc_pkg::RAIL_ENABLE_CTRL_OFS
      || i_reg_addr > prc_pkg::POWER_LEVEL_CTRL_OFS)
    |=> o_reg_rdata == 8'h00 && !o_reg_hit)
    else $error("unmapped read not empty");
  AST_UNMAPPED_WRITE: assert property (@(posedge i_clk_sys) // [R16]
    disable iff (!i_nrst)
    i_reg_wr && (i_reg_addr < prc_pkg::RAIL_ENABLE_CTRL_OFS
      || i_reg_addr > prc_pkg::POWER_LEVEL_CTRL_OFS)
    |=> $stable(rail_enable_ctrl_ff) && $stable(sleep_ctrl_ff)
      && $stable(buck_switching_mode_ctrl_ff)
      && $stable(output_discharge_ctrl_ff) && $stable(power_level_ctrl_ff))
    else $error("unmapped write changed a register");

  COV_SLEEP_ENTRY: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) $rose(o_sleep_active));
  COV_KEPT_ALIVE: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) sleep_req && o_buck_on[2]);
  COV_FORCED_PWM: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) o_buck_forced_switching[0]);
  COV_SLEEP_EXIT: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) $fell(o_sleep_active));
  COV_UNMAPPED: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) i_reg_rd && !nxt_hit);

endmodule : prc_power_rail_control_regs
`default_nettype wire

// ---- test/prc_host_model.sv ----
// Host side model issuing register accesses on the control port
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Requests towards the bank
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  // Answer from the bank
  input wire logic [7:0] i_rdata,
  input wire logic i_hit
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // Idle bus shows inverted values, never the stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic h);
    @(negedge i_clk_sys);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk_sys);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    h = i_hit;
  endtask : rd
endmodule : prc_host_model
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the rail control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk_sys, i_nrst, wr, rd, hit, h;
  logic [7:0] addr, wdata, rdata, d;
  logic [3:0] b_on, b_lp, b_fs, b_dis;
  logic l_on, l_lp, l_dis, s_on, s_dis, slp;
  int bad_count, comparisons;
  logic [7:0] ofs [5] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13};
  logic [7:0] rst_v [5] = '{8'h00, 8'h1C, 8'h00, 8'hF8, 8'h00};
  logic [7:0] msk [5] = '{8'hDE, 8'hBD, 8'hF0, 8'hFC, 8'hBC};
  wire [21:0] outs = {b_on, b_lp, b_fs, b_dis,
                      l_on, l_lp, l_dis, s_on, s_dis, slp};

  prc_power_rail_control_regs dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_hit(hit), .o_buck_on(b_on),
    .o_buck_low_power(b_lp), .o_buck_forced_switching(b_fs),
    .o_buck_discharge(b_dis), .o_linear_reg_on(l_on),
    .o_linear_reg_low_power(l_lp), .o_linear_reg_discharge(l_dis),
    .o_load_switch_on(s_on), .o_load_switch_discharge(s_dis),
    .o_sleep_active(slp));

  prc_host_model host (
    .i_clk_sys(i_clk_sys), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .i_hit(hit));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // Run needs well under 200 cycles
  initial begin
    #(2000 * 40);
    bad_count++;
    stop_test();
  end

  initial begin
    bad_count = 0;
    comparisons = 0;
    i_nrst = 1'b0;
    repeat (16) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    check(outs, {4'h0, 4'h0, 4'h0, 4'hF, 6'b001000});
    for (int i = 0; i < 5; i++) begin
      host.rd(ofs[i], d, h);
      check({h, d}, {1'b1, rst_v[i]});
    end
    for (int i = 0; i < 5; i++) begin
      host.wr(ofs[i], 8'hFF);
    end
    for (int i = 0; i < 5; i++) begin
      host.rd(ofs[i], d, h);
      check(d, msk[i]);
    end
    // Unmapped place: write ignored, read empty, no hit
    host.wr(8'h14, 8'hFF);
    host.rd(8'h14, d, h);
    check({h, d}, 9'h000);
    // All rails kept alive in sleep go low power
    check(outs, {4'hF, 4'hF, 4'h0, 4'h0, 6'b110101});
    host.wr(8'h13, 8'h88);
    check(outs, {4'hF, 4'hF, 4'h0, 4'h0, 6'b110101});
    host.wr(8'h10, 8'h89);
    check(outs, {4'h9, 4'h9, 4'h0, 4'h6, 6'b001101});
    host.wr(8'h10, 8'h88);
    check(outs, {4'hF, 4'h9, 4'h6, 4'h0, 6'b100100});
    host.wr(8'h13, 8'h8C);
    check(outs, {4'hF, 4'h9, 4'h6, 4'h0, 6'b110100});
    host.wr(8'h13, 8'h00);
    host.wr(8'h0F, 8'h40);
    check(outs, {4'h1, 4'h0, 4'h1, 4'hE, 6'b001010});
    host.wr(8'h0F, 8'h00);
    check(outs, {4'h0, 4'h0, 4'h0, 4'hF, 6'b001010});
    host.wr(8'h12, 8'h00);
    check(outs, {4'h0, 4'h0, 4'h0, 4'h0, 6'b000000});
    // Sleep with nothing kept drops buck 1, wake restores it
    host.wr(8'h0F, 8'h40);
    host.wr(8'h10, 8'h01);
    check(outs, {4'h0, 4'h0, 4'h0, 4'h0, 6'b000001});
    host.wr(8'h10, 8'h00);
    check(outs, {4'h1, 4'h0, 4'h1, 4'h0, 6'b000000});
    stop_test();
  end
endmodule : testbench
`default_nettype wire
